// ### hdl/digit_check_params.svh
// constants for the instruction digit validity checker
// assumes one 100 mhz clock; included by the package and the design files
//
// Function
// - compare each duplicated operand register pair; mismatch sets error, blocks time-out reset.
// - comparison error stays until new contents load into that register pair or initial clear.
// - undecodable first digit gives no function signals; machine stalls in time-on.
// - after instruction setup in time-out, time-out flag resets after one minor cycle.
// - stop control sets the time-out flag and the stop flip-flops.
// - control counter increments in beta phase, pointing past the fetched word.
// - shift moves the accumulator one digit per stage counter step.
// - shift ends when second-digit line equals stage line, pulse at stage close.
// - undecodable shift count runs to stage 1101, then stops and flags intermediate error.
// - skip differs from shift-left-without-sign only by zero second digit.
// - fourth and fifth digits together select one memory channel.
// - fourth and fifth decode outputs each checked one-hot, each with own flag.
// - tank selection error stalls the machine in the next time-out.
// - tank flags survive start; clear only after clean time-selection instruction.
// - invalid sixth digit stalls every one- or two-word memory transfer.
// - two time-select circuits compare counter with sixth digit, each setting own flag.
// - only one circuit checks odd-even; bad check pulse leaves it clear.
// - memory transfer needs both time-select flags; ending pulse from time selection.
// - sixth digit numeric part outside 0-9 sets neither time-select flag.
// - general clear resets both time-select flags, including a lone unchecked one.
`ifndef DIGIT_CHECK_PARAMS_SVH
`define DIGIT_CHECK_PARAMS_SVH
`define DIGIT_W 7
`define WORD_W 84
`define CC_W 12
`define STAGE_W 4
`define STAGE_LAST 4'hd
`define MINOR_CYCLE_NS 10
`define CLK_PERIOD_NS 10
`define MINOR_CYCLES ((`MINOR_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MINOR_CNT_W 4
`define NUM_PAIRS 4
`define OP_SHIFT 4'h1
`define OP_SKIP 4'h2
`define OP_MEM 4'h3
`define OP_OTHER 4'h4
`define TS_MAX 4'h9
`endif

// ### hdl/digit_check_pkg.sv
// types for the instruction digit validity checker
// assumes the params header is on the include path
`include "digit_check_params.svh"
package digit_check_pkg;
  // one-hot control sequencer states
  typedef enum logic [4:0] {
    ST_TIME_OUT = 5'b00001,
    ST_TIME_ON = 5'b00010,
    ST_STALL_ON = 5'b00100,
    ST_STOPPED = 5'b01000,
    ST_STALL_OUT = 5'b10000
  } seq_state_t;
  typedef logic [3:0] op_class_t;
endpackage

// ### hdl/onehot_checker.sv
// one-hot checker for a digit decoding table output
// assumes a combinational decode on the same clock feeding it
`timescale 1ns/1ns
module onehot_checker #(
  parameter int W = 10
) (
  input wire logic [W-1:0] lines,
  output logic ok
);
  // ok only when exactly one line is active
  always_comb begin
    ok = (lines != '0) && ((lines & (lines - 1'b1)) == '0);
  end
endmodule

// ### hdl/instruction_digit_validity_checker.sv
// instruction hold register checks: digit decode, shift end, tank and time select
// assumes panel switches arrive through synchronisers; word timing from the core
`timescale 1ns/1ns
`include "digit_check_params.svh"
module instruction_digit_validity_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic load_instr,
  input wire logic [`WORD_W-1:0] instr_in,
  input wire logic [`NUM_PAIRS-1:0] pair_load,
  input wire logic [`NUM_PAIRS*`DIGIT_W-1:0] pair_main,
  input wire logic [`NUM_PAIRS*`DIGIT_W-1:0] pair_dup,
  input wire logic [3:0] word_time_select,
  input wire logic beta_phase,
  input wire logic stop_sw,
  input wire logic start_sw,
  input wire logic general_clear_sw,
  input wire logic initial_clear,
  input wire logic [`NUM_PAIRS-1:0] comp_delete_sw,
  input wire logic tank_delete_sw,
  output logic [`WORD_W-1:0] instruction_hold_register,
  output logic time_out_flag,
  output logic stop_flag,
  output logic stall,
  output logic [`CC_W-1:0] control_counter,
  output logic [`STAGE_W-1:0] stage_counter,
  output logic shift_step,
  output logic ending_pulse,
  output logic skip_op,
  output logic [`NUM_PAIRS-1:0] comp_error,
  output logic ft_intermediate_error,
  output logic tank_error_upper,
  output logic tank_error_lower,
  output logic [1:0] time_select_flag,
  output logic mem_transfer_go,
  output logic [19:0] channel_select
);
  // ************************************************************
  // panel switch synchronisers
  // ************************************************************
  logic [2:0] stop_s_q, stop_s_d, start_s_q, start_s_d, gclr_s_q, gclr_s_d;
  logic [2:0] tdel_s_q, tdel_s_d;
  logic stop_lv, start_lv, gclr_lv, tdel_lv, start_prev_q, start_prev_d, start_evt;
  // a change counts once the second and third stages agree
  always_comb begin
    stop_s_d = {stop_s_q[1:0], stop_sw};
    start_s_d = {start_s_q[1:0], start_sw};
    gclr_s_d = {gclr_s_q[1:0], general_clear_sw};
    tdel_s_d = {tdel_s_q[1:0], tank_delete_sw};
    start_prev_d = start_lv;
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stop_s_q <= 3'h0;
      start_s_q <= 3'h0;
      gclr_s_q <= 3'h0;
      tdel_s_q <= 3'h0;
      start_prev_q <= 1'b0;
    end else begin
      stop_s_q <= stop_s_d;
      start_s_q <= start_s_d;
      gclr_s_q <= gclr_s_d;
      tdel_s_q <= tdel_s_d;
      start_prev_q <= start_prev_d;
    end
  end
  // filtered levels hold their old value while the two stages disagree
  logic stop_f_q, start_f_q, gclr_f_q, tdel_f_q;
  logic stop_f_d, start_f_d, gclr_f_d, tdel_f_d;
  always_comb begin
    stop_f_d = (stop_s_q[1] == stop_s_q[2]) ? stop_s_q[2] : stop_f_q;
    start_f_d = (start_s_q[1] == start_s_q[2]) ? start_s_q[2] : start_f_q;
    gclr_f_d = (gclr_s_q[1] == gclr_s_q[2]) ? gclr_s_q[2] : gclr_f_q;
    tdel_f_d = (tdel_s_q[1] == tdel_s_q[2]) ? tdel_s_q[2] : tdel_f_q;
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stop_f_q <= 1'b0;
      start_f_q <= 1'b0;
      gclr_f_q <= 1'b0;
      tdel_f_q <= 1'b0;
    end else begin
      stop_f_q <= stop_f_d;
      start_f_q <= start_f_d;
      gclr_f_q <= gclr_f_d;
      tdel_f_q <= tdel_f_d;
    end
  end
  assign stop_lv = stop_f_q;
  assign start_lv = start_f_q;
  assign gclr_lv = gclr_f_q;
  assign tdel_lv = tdel_f_q;
  assign start_evt = start_lv & ~start_prev_q;

  // ************************************************************
  // digit decoding
  // ************************************************************
  logic [`DIGIT_W-1:0] d1, d2, d4, d5, d6;
  logic [3:0] n2, n4, n5, n6;
  logic [9:0] line2, line4, line5;
  logic [15:0] stage_line;
  logic d1_valid, d6_odd, d6_num_ok, ok4, ok5;
  digit_check_pkg::op_class_t op_class;
  assign d1 = instruction_hold_register[`WORD_W-1 -: `DIGIT_W];
  assign d2 = instruction_hold_register[`WORD_W-1-`DIGIT_W -: `DIGIT_W];
  assign d4 = instruction_hold_register[`WORD_W-1-3*`DIGIT_W -: `DIGIT_W];
  assign d5 = instruction_hold_register[`WORD_W-1-4*`DIGIT_W -: `DIGIT_W];
  assign d6 = instruction_hold_register[`WORD_W-1-5*`DIGIT_W -: `DIGIT_W];
  assign n2 = d2[3:0];
  assign n4 = d4[3:0];
  assign n5 = d5[3:0];
  assign n6 = d6[3:0];
  // a digit with any zone bit set is alphabetic and decodes to no line
  always_comb begin
    line2 = '0;
    line4 = '0;
    line5 = '0;
    stage_line = '0;
    if (d2[5:4] == 2'h0 && n2 <= `TS_MAX) begin
      line2[n2] = 1'b1;
    end
    if (d4[5:4] == 2'h0 && n4 <= `TS_MAX) begin
      line4[n4] = 1'b1;
    end
    if (d5[5:4] == 2'h0 && n5 <= `TS_MAX) begin
      line5[n5] = 1'b1;
    end
    stage_line[stage_counter] = 1'b1;
  end
  // first digit table: a small set of encodings standing for the order classes
  always_comb begin
    op_class = 4'h0;
    case (d1[5:0])
      6'h01: op_class = `OP_SHIFT;
      6'h02: op_class = `OP_MEM;
      6'h03: op_class = `OP_OTHER;
      6'h00: op_class = (n2 == 4'h0 && d2[5:4] == 2'h0) ? `OP_SKIP : `OP_SHIFT;
      default: op_class = 4'h0;
    endcase
  end
  assign d1_valid = (op_class != 4'h0);
  assign skip_op = (op_class == `OP_SKIP);
  assign d6_odd = ^d6;
  assign d6_num_ok = (d6[5:4] == 2'h0) && (n6 <= `TS_MAX);
  onehot_checker #(.W(10)) chk4 (.lines(line4), .ok(ok4));
  onehot_checker #(.W(10)) chk5 (.lines(line5), .ok(ok5));
  assign channel_select = {line4, line5};

  // ************************************************************
  // sequencer and error flags
  // ************************************************************
  digit_check_pkg::seq_state_t st_q, st_d;
  logic [`MINOR_CNT_W-1:0] minor_q, minor_d;
  logic [`NUM_PAIRS-1:0] comp_q, comp_d, comp_block;
  logic ft_q, ft_d, tu_q, tu_d, tl_q, tl_d, stop_q, stop_d;
  logic [1:0] ts_q, ts_d;
  logic [`STAGE_W-1:0] stg_q, stg_d;
  logic [`CC_W-1:0] cc_q, cc_d;
  logic [`WORD_W-1:0] ihr_q, ihr_d;
  logic block_to, tank_err, shift_hit, end_now;
  assign comp_block = comp_q & ~comp_delete_sw;
  assign tank_err = (tu_q | tl_q) & ~tdel_lv;
  assign block_to = (comp_block != '0);
  assign shift_hit = ((line2 & stage_line[9:0]) != '0);
  assign mem_transfer_go = &ts_q;
  // one stage per minor cycle, ending pulse chosen by order class
  always_comb begin
    end_now = 1'b0;
    if (st_q == digit_check_pkg::ST_TIME_ON && d1_valid) begin
      case (op_class)
        `OP_SHIFT: end_now = shift_hit;
        `OP_MEM: end_now = mem_transfer_go;
        `OP_SKIP: end_now = 1'b1;
        `OP_OTHER: end_now = 1'b1;
        default: end_now = 1'b0;
      endcase
    end
  end
  always_comb begin
    st_d = st_q;
    minor_d = minor_q;
    stop_d = stop_q;
    stg_d = stg_q;
    cc_d = cc_q;
    ihr_d = ihr_q;
    ft_d = ft_q;
    tu_d = tu_q;
    tl_d = tl_q;
    ts_d = ts_q;
    // comparison errors: a fresh load clears, a mismatch wins over it
    for (int i = 0; i < `NUM_PAIRS; i++) begin
      if (pair_load[i] || initial_clear) begin
        comp_d[i] = 1'b0;
      end else begin
        comp_d[i] = comp_q[i];
      end
      if (pair_main[i*`DIGIT_W +: `DIGIT_W] != pair_dup[i*`DIGIT_W +: `DIGIT_W]) begin
        comp_d[i] = 1'b1;
      end
    end
    // start clears the runaway flag; a set in the same cycle below still wins
    if (start_evt) begin
      ft_d = 1'b0;
    end
    if (beta_phase) begin
      cc_d = cc_q + 1'b1;
    end
    // time selection: both circuits compare, only the second checks odd-even
    if (st_q == digit_check_pkg::ST_TIME_ON && op_class == `OP_MEM && d6_num_ok) begin
      if (word_time_select == n6) begin
        ts_d[0] = 1'b1;
        ts_d[1] = d6_odd;
      end
    end
    case (st_q)
      digit_check_pkg::ST_TIME_OUT: begin
        if (load_instr) begin
          ihr_d = instr_in;
          minor_d = '0;
        end else if (block_to) begin
          st_d = digit_check_pkg::ST_STALL_OUT;
        end else if (minor_q >= `MINOR_CNT_W'(`MINOR_CYCLES - 1)) begin
          st_d = digit_check_pkg::ST_TIME_ON;
          tu_d = tu_q | ~ok4;
          tl_d = tl_q | ~ok5;
        end else begin
          minor_d = minor_q + 1'b1;
        end
      end
      digit_check_pkg::ST_TIME_ON: begin
        if (!d1_valid) begin
          st_d = digit_check_pkg::ST_STALL_ON;
        end else if (end_now) begin
          st_d = digit_check_pkg::ST_TIME_OUT;
          stg_d = '0;
          minor_d = '0;
          if (op_class == `OP_MEM) begin
            // only a transfer whose own channel digits decoded cleanly counts as error free
            if (ok4 && ok5) begin
              tu_d = 1'b0;
              tl_d = 1'b0;
            end
            ts_d = 2'h0;
          end
        end else if (op_class == `OP_SHIFT && stg_q == `STAGE_LAST) begin
          st_d = digit_check_pkg::ST_STOPPED;
          ft_d = 1'b1;
          stop_d = 1'b1;
        end else if (op_class == `OP_SHIFT) begin
          stg_d = stg_q + 1'b1;
        end
      end
      digit_check_pkg::ST_STALL_OUT: begin
        if (start_evt && !tank_err) begin
          st_d = digit_check_pkg::ST_TIME_OUT;
          minor_d = '0;
        end
      end
      default: begin
        if (start_evt) begin
          st_d = digit_check_pkg::ST_TIME_OUT;
          minor_d = '0;
          stop_d = 1'b0;
        end
      end
    endcase
    // tank error stalls in the next time-out
    if (st_d == digit_check_pkg::ST_TIME_OUT && st_q != digit_check_pkg::ST_TIME_OUT
        && tank_err) begin
      st_d = digit_check_pkg::ST_STALL_OUT;
    end
    if (stop_lv) begin
      st_d = digit_check_pkg::ST_STOPPED;
      stop_d = 1'b1;
    end
    if (gclr_lv) begin
      ts_d = 2'h0;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= digit_check_pkg::ST_TIME_OUT;
      minor_q <= '0;
      stop_q <= 1'b0;
      stg_q <= '0;
      cc_q <= '0;
      ihr_q <= '0;
      ft_q <= 1'b0;
      tu_q <= 1'b0;
      tl_q <= 1'b0;
      ts_q <= 2'h0;
      comp_q <= '0;
    end else begin
      st_q <= st_d;
      minor_q <= minor_d;
      stop_q <= stop_d;
      stg_q <= stg_d;
      cc_q <= cc_d;
      ihr_q <= ihr_d;
      ft_q <= ft_d;
      tu_q <= tu_d;
      tl_q <= tl_d;
      ts_q <= ts_d;
      comp_q <= comp_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // time-out also reads high while stopped, as stop sets the flag
  assign time_out_flag = (st_q != digit_check_pkg::ST_TIME_ON)
                         && (st_q != digit_check_pkg::ST_STALL_ON);
  assign stop_flag = stop_q;
  assign stall = (st_q == digit_check_pkg::ST_STALL_ON) || (st_q == digit_check_pkg::ST_STALL_OUT)
                 || (st_q == digit_check_pkg::ST_TIME_ON && op_class == `OP_MEM && !end_now);
  assign control_counter = cc_q;
  assign stage_counter = stg_q;
  assign instruction_hold_register = ihr_q;
  assign shift_step = (st_q == digit_check_pkg::ST_TIME_ON) && (op_class == `OP_SHIFT);
  assign ending_pulse = end_now;
  assign comp_error = comp_q;
  assign ft_intermediate_error = ft_q;
  assign tank_error_upper = tu_q;
  assign tank_error_lower = tl_q;
  assign time_select_flag = ts_q;
endmodule

// ### tb/digit_checker.sv
// concurrent checks on the instruction digit validity checker ports
// assumes it is bound onto the design top; one clock, async active-low reset
`timescale 1ns/1ns
`include "digit_check_params.svh"
module digit_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic load_instr,
  input wire logic [`NUM_PAIRS-1:0] pair_load,
  input wire logic [`NUM_PAIRS*`DIGIT_W-1:0] pair_main,
  input wire logic [`NUM_PAIRS*`DIGIT_W-1:0] pair_dup,
  input wire logic beta_phase,
  input wire logic stop_sw,
  input wire logic general_clear_sw,
  input wire logic initial_clear,
  input wire logic [`WORD_W-1:0] instruction_hold_register,
  input wire logic time_out_flag,
  input wire logic stop_flag,
  input wire logic stall,
  input wire logic [`CC_W-1:0] control_counter,
  input wire logic [`STAGE_W-1:0] stage_counter,
  input wire logic shift_step,
  input wire logic ending_pulse,
  input wire logic [`NUM_PAIRS-1:0] comp_error,
  input wire logic ft_intermediate_error,
  input wire logic tank_error_upper,
  input wire logic [1:0] time_select_flag,
  input wire logic mem_transfer_go
);
  // ********************
  // properties
  // ********************
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // panel levels pass a 3-flop synchroniser and a filter flop, so six held cycles is just enough
  sequence s_stop_held;
    stop_sw [*6];
  endsequence
  sequence s_clear_held;
    general_clear_sw [*6];
  endsequence
  // the last edge of a load taken in time-out, followed by the request dropping
  sequence s_last_load;
    load_instr && time_out_flag && !stop_flag && !stall && comp_error == 4'h0 ##1 !load_instr;
  endsequence
  property p_comp_set;
    (pair_main[13:7] != pair_dup[13:7]) |=> comp_error[1];
  endproperty
  a_comp_set: assert property (p_comp_set) else $error("pair mismatch not flagged");
  property p_comp_hold;
    comp_error[1] && !pair_load[1] && !initial_clear |=> comp_error[1];
  endproperty
  a_comp_hold: assert property (p_comp_hold) else $error("pair error dropped");
  property p_load_end;
    s_last_load |=> !time_out_flag;
  endproperty
  a_load_end: assert property (p_load_end) else $error("time-out did not end");
  property p_stop;
    s_stop_held |-> stop_flag && time_out_flag;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not set flags");
  property p_beta;
    beta_phase |=> control_counter == $past(control_counter) + 1'b1;
  endproperty
  a_beta: assert property (p_beta) else $error("control counter missed step");
  property p_shift_adv;
    shift_step && !ending_pulse && stage_counter != `STAGE_LAST
      |=> stage_counter == $past(stage_counter) + 1'b1;
  endproperty
  a_shift_adv: assert property (p_shift_adv) else $error("stage did not advance");
  property p_shift_end;
    ending_pulse && shift_step |-> stage_counter == instruction_hold_register[73:70];
  endproperty
  a_shift_end: assert property (p_shift_end) else $error("shift ended wrong stage");
  property p_ft_last;
    $rose(ft_intermediate_error) |-> stage_counter == `STAGE_LAST;
  endproperty
  a_ft_last: assert property (p_ft_last) else $error("runaway flag at wrong stage");
  property p_tank_hold;
    tank_error_upper && !ending_pulse |=> tank_error_upper;
  endproperty
  a_tank_hold: assert property (p_tank_hold) else $error("tank flag dropped");
  property p_parity;
    ^instruction_hold_register[48:42] == 1'b0 && !load_instr && !time_select_flag[1]
      |=> !time_select_flag[1];
  endproperty
  a_parity: assert property (p_parity) else $error("checked flag set on bad digit");
  property p_go;
    mem_transfer_go |-> time_select_flag == 2'b11;
  endproperty
  a_go: assert property (p_go) else $error("transfer without both flags");
  property p_range;
    instruction_hold_register[45:42] > `TS_MAX && !load_instr && time_select_flag == 2'b00
      |=> time_select_flag == 2'b00;
  endproperty
  a_range: assert property (p_range) else $error("flag set on out of range digit");
  property p_gclr;
    s_clear_held |-> time_select_flag == 2'b00;
  endproperty
  a_gclr: assert property (p_gclr) else $error("general clear left flags");
endmodule
bind instruction_digit_validity_checker digit_checker digit_checker_inst (
  .core_clk, .resetn, .load_instr, .pair_load, .pair_main, .pair_dup, .beta_phase,
  .stop_sw, .general_clear_sw, .initial_clear, .instruction_hold_register, .time_out_flag,
  .stop_flag, .stall, .control_counter, .stage_counter, .shift_step, .ending_pulse,
  .comp_error, .ft_intermediate_error, .tank_error_upper, .time_select_flag,
  .mem_transfer_go);

// ### tb/panel_model.sv
// stand-in for the supervisory panel: press requests become held switch levels
// assumes the bench raises a stop, start or clear press bit for a single clock
`timescale 1ns/1ns
module panel_model (
  input wire logic core_clk,
  input wire logic [3:0] press,
  output logic stop_sw,
  output logic start_sw,
  output logic general_clear_sw,
  output logic tank_delete_sw = 1'b0
);
  // ********************
  // switch timing
  // ********************
  logic [3:0] hold_q [3] = '{default: 4'h0};
  // a stop, start or clear press stays down 8 clocks so it survives the design's synchroniser; tank delete follows its press bit directly
  always @(posedge core_clk) begin
    for (int i = 0; i < 3; i++) begin
      hold_q[i] <= press[i] ? 4'h8 : (hold_q[i] != 4'h0 ? hold_q[i] - 4'h1 : 4'h0);
    end
    tank_delete_sw <= press[3];
  end
  assign stop_sw = hold_q[0] != 4'h0;
  assign start_sw = hold_q[1] != 4'h0;
  assign general_clear_sw = hold_q[2] != 4'h0;
endmodule

// ### tb/tb_top.sv
// self-checking bench for the instruction digit validity checker
// assumes the panel model and the bound checker; one 100 mhz clock
`timescale 1ns/1ns
`include "digit_check_params.svh"
module tb_top;
  // ********************
  // stimulus and checks
  // ********************
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic load_instr = 1'b0;
  logic beta_phase = 1'b0;
  logic initial_clear = 1'b0;
  logic [`WORD_W-1:0] instr_in = '0;
  logic [`NUM_PAIRS-1:0] pair_load = '0;
  logic [`NUM_PAIRS*`DIGIT_W-1:0] pair_main = '0;
  logic [`NUM_PAIRS*`DIGIT_W-1:0] pair_dup = '0;
  logic [3:0] word_time_select = 4'h0;
  logic [3:0] press = 4'h0;
  logic stop_sw, start_sw, general_clear_sw, tank_delete_sw;
  logic time_out_flag, stop_flag, stall, shift_step, ending_pulse, skip_op, mem_transfer_go;
  logic ft_intermediate_error, tank_error_upper, tank_error_lower;
  logic [`WORD_W-1:0] instruction_hold_register;
  logic [`CC_W-1:0] control_counter;
  logic [`STAGE_W-1:0] stage_counter;
  logic [`NUM_PAIRS-1:0] comp_error;
  logic [1:0] time_select_flag;
  logic [19:0] channel_select;
  int failures = 0;
  int check_count = 0;
  localparam logic [6:0] DZ = 7'h40;
  instruction_digit_validity_checker instruction_digit_validity_checker_inst (
    .core_clk, .resetn, .load_instr, .instr_in, .pair_load, .pair_main, .pair_dup,
    .word_time_select, .beta_phase, .stop_sw, .start_sw, .general_clear_sw, .initial_clear,
    .comp_delete_sw(4'h0), .tank_delete_sw, .instruction_hold_register, .time_out_flag,
    .stop_flag, .stall, .control_counter, .stage_counter, .shift_step, .ending_pulse,
    .skip_op, .comp_error, .ft_intermediate_error, .tank_error_upper, .tank_error_lower,
    .time_select_flag, .mem_transfer_go, .channel_select);
  panel_model panel_model_inst (.core_clk, .press, .stop_sw, .start_sw, .general_clear_sw,
    .tank_delete_sw);
  always #5 core_clk = ~core_clk;
  // word time counter sweeps 0-9 like the memory timing would
  always @(posedge core_clk) begin
    word_time_select <= (word_time_select == 4'h9) ? 4'h0 : word_time_select + 4'h1;
  end
  // a digit with its check bit set for an odd pulse count
  function automatic logic [6:0] dg(input logic [1:0] z, input logic [3:0] n);
    return {~^{z, n}, z, n};
  endfunction
  function automatic logic [`WORD_W-1:0] mk(input logic [6:0] d1, d2, d4, d5, d6);
    return {d1, d2, DZ, d4, d5, d6, {6{DZ}}};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // sample a settled nanosecond after the edge
  task automatic run(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    for (int i = 0; i < lim && s !== 1'b1; i++) run(1);
  endtask
  task automatic do_reset;
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
  endtask
  task automatic load(input logic [`WORD_W-1:0] w);
    @(posedge core_clk);
    instr_in <= w;
    load_instr <= 1'b1;
    // the word lands only in a time-out cycle, so hold until it shows, then one edge more
    run(1);
    for (int i = 0; i < 20 && instruction_hold_register !== w; i++) run(1);
    @(posedge core_clk);
    load_instr <= 1'b0;
  endtask
  task automatic push(input int b);
    @(posedge core_clk);
    press[b] <= 1'b1;
    @(posedge core_clk);
    press[b] <= 1'b0;
    run(10);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard, far beyond the several hundred cycles the tests need
  initial begin
    #200000;
    failures++;
    close_out();
  end
  initial begin
    int n;
    logic [3:0] c [3];
    logic [3:0] a, b;
    void'($urandom(21));
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    run(1);
    n = $urandom_range(12, 3);
    repeat (n) begin
      @(posedge core_clk);
      beta_phase <= 1'b1;
      @(posedge core_clk);
      beta_phase <= 1'b0;
    end
    run(1);
    chk(control_counter, n);
    $display("test control counter done");
    c = '{4'h1, 4'h9, 4'($urandom_range(8, 2))};
    foreach (c[i]) begin
      do_reset();
      load(mk(dg(2'h0, 4'h1), dg(2'h0, c[i]), DZ, DZ, DZ));
      run(1);
      chk(time_out_flag, 1'b0);
      wait_hi(ending_pulse, 20);
      chk(stage_counter, c[i]);
    end
    do_reset();
    load(mk(dg(2'h0, 4'h1), dg(2'h1, 4'h4), DZ, DZ, DZ));
    wait_hi(ft_intermediate_error, 30);
    chk(stage_counter, `STAGE_LAST);
    chk(stop_flag, 1'b1);
    $display("test shift done");
    for (int k = 0; k < 2; k++) begin
      do_reset();
      load(mk(dg(2'h0, 4'h0), dg(2'h0, 4'(k * 5)), DZ, DZ, DZ));
      run(1);
      chk(skip_op, k == 0);
    end
    do_reset();
    load(mk(dg(2'h3, 4'hf), DZ, DZ, DZ, DZ));
    run(6);
    chk(stall, 1'b1);
    chk(time_out_flag, 1'b0);
    push(0);
    chk({stop_flag, time_out_flag}, 2'b11);
    $display("test decode done");
    do_reset();
    pair_main[13:7] <= 7'($urandom_range(127, 1));
    load(mk(dg(2'h0, 4'h3), DZ, DZ, DZ, DZ));
    pair_main <= '0;
    run(6);
    chk(time_out_flag, 1'b1);
    chk(comp_error, 4'h2);
    pair_load[1] <= 1'b1;
    run(1);
    pair_load[1] <= 1'b0;
    run(1);
    chk(comp_error, 4'h0);
    $display("test comparison done");
    for (int k = 0; k < 4; k++) begin
      do_reset();
      a = 4'($urandom_range(9, 0));
      b = 4'($urandom_range(9, 0));
      n = $urandom_range(9, 0);
      load(mk(dg(2'h0, 4'h2), DZ, dg(2'h0, a), dg(2'h0, b), dg(2'h0, 4'(n))));
      run(1);
      chk(channel_select, {10'h1 << a, 10'h1 << b});
      wait_hi(mem_transfer_go, 30);
      chk(time_select_flag, 2'b11);
      chk({tank_error_upper, tank_error_lower}, 2'b00);
    end
    do_reset();
    load(mk(dg(2'h0, 4'h2), DZ, DZ, DZ, dg(2'h0, 4'h7) ^ 7'h40));
    run(25);
    chk(time_select_flag, 2'b01);
    chk({stall, mem_transfer_go}, 2'b10);
    push(0);
    push(2);
    chk(time_select_flag, 2'b00);
    do_reset();
    load(mk(dg(2'h0, 4'h2), DZ, DZ, DZ, dg(2'h0, 4'hc)));
    run(25);
    chk({stall, time_select_flag}, 3'b100);
    $display("test time selection done");
    for (int k = 0; k < 2; k++) begin
      do_reset();
      load(mk(dg(2'h0, 4'h2), DZ, k ? DZ : dg(2'h1, 4'h3), k ? dg(2'h2, 4'h5) : DZ, DZ));
      run(30);
      chk({tank_error_upper, tank_error_lower}, k ? 2'b01 : 2'b10);
      chk(stall, 1'b1);
      push(1);
      chk(tank_error_upper | tank_error_lower, 1'b1);
      press[3] <= 1'b1;
      push(1);
      load(mk(dg(2'h0, 4'h2), DZ, DZ, DZ, DZ));
      run(40);
      press[3] <= 1'b0;
      chk({tank_error_upper, tank_error_lower}, 2'b00);
    end
    $display("test tank selection done");
    close_out();
  end
endmodule
